// *** design/rced_defines.vh ***
// constants for the root and context entry decoder
`ifndef RCED_DEFINES_VH
`define RCED_DEFINES_VH

// register byte offsets
`define RCED_OFF_CTRL      8'h00
`define RCED_OFF_CAP       8'h04
`define RCED_OFF_STATUS    8'h08
`define RCED_OFF_UPTR_LO   8'h0C
`define RCED_OFF_UPTR_HI   8'h10
`define RCED_OFF_LPTR_LO   8'h14
`define RCED_OFF_LPTR_HI   8'h18
`define RCED_OFF_DTAG      8'h1C
`define RCED_OFF_ENTRY0    8'h20
`define RCED_OFF_CTX_UPPER 8'h30
// ctrl fields
`define RCED_CTRL_FMT      0
`define RCED_CTRL_CMODE    1
// status fields
`define RCED_ST_UVALID     0
`define RCED_ST_LVALID     1
`define RCED_ST_EXT        2
`define RCED_ST_RSVDERR    3
`define RCED_ST_TAGERR     4
// entry field positions
`define RCED_UPTR_LSB      76
`define RCED_UVALID_BIT    64
`define RCED_LPTR_LSB      12
`define RCED_LVALID_BIT    0
`define RCED_DTAG_LSB      72
`define RCED_DTAG_MSB      87
`define RCED_CTX_RSVD_LSB  88
`define RCED_TABLE_SHIFT   12
// reset values
`define RCED_CTRL_RST      2'h0
// axi responses
`define RCED_RESP_OKAY     2'h0
`define RCED_RESP_SLVERR   2'h2

`endif

// *** design/rced_entry_decode.v ***
// extended root entry and context entry decoder with axi4-lite registers
// Behaviour
// R1: format select set means root entries decode as 128-bit extended entries.
// R2: upper table base from bits 127:76, bits at width+64 and up forced zero.
// R3: bit 64 marks upper half valid; clear makes bits 127:65 ignored.
// R4: lower table base from bits 63:12, bits at width and up forced zero.
// R5: bit 0 marks lower half valid; clear makes bits 63:1 ignored.
// R6: software zeroes reserved ranges 75:65, 11:1 and context 127:88.
// R7: context entries via root entries translate requests without PASID.
// R8: domain tag comes from context bits 87:72, labels cached entries.
// R9: supported domain tag width is readable in a capability register.
// R10: tag bits above supported width are treated as reserved.
// R11: software keeps tags and second level tables one to one.
// R12: format select clear means legacy single pointer root entries.
// R13: in caching mode software never uses domain tag zero.
// R14: each 128-bit entry is taken whole, bit 0 lowest byte LSB.
`timescale 1ns/1ps
`include "rced_defines.vh"

module rced_entry_decode #(
	parameter HOST_ADDR_WIDTH = 48,
	parameter TAG_WIDTH       = 16
) (
	// clock and reset
	input  wire         sys_clk,
	input  wire         resetn,
	// entry fetch from the table walker
	input  wire         entryValid,
	input  wire [127:0] entryData,
	input  wire         entryIsContext,
	// decoded root entry
	output reg  [63:0]  upperTableBase,
	output reg          upperPresent,
	output reg  [63:0]  lowerTableBase,
	output reg          lowerPresent,
	output reg          rootDone,
	// decoded context entry
	output reg  [15:0]  domainTag,
	output reg          ctxDone,
	output reg          ctxRsvdErr,
	output reg          ctxTagErr,
	// axi4-lite slave
	input  wire [7:0]   s_axi_awaddr,
	input  wire         s_axi_awvalid,
	output wire         s_axi_awready,
	input  wire [31:0]  s_axi_wdata,
	input  wire [3:0]   s_axi_wstrb,
	input  wire         s_axi_wvalid,
	output wire         s_axi_wready,
	output reg  [1:0]   s_axi_bresp,
	output reg          s_axi_bvalid,
	input  wire         s_axi_bready,
	input  wire [7:0]   s_axi_araddr,
	input  wire         s_axi_arvalid,
	output wire         s_axi_arready,
	output reg  [31:0]  s_axi_rdata,
	output reg  [1:0]   s_axi_rresp,
	output reg          s_axi_rvalid,
	input  wire         s_axi_rready
);

	reg  [1:0]   ctrl;
	reg  [127:0] lastEntry;
	reg  [7:0]   awAddr;
	reg          awHeld;
	reg  [31:0]  wData;
	reg  [3:0]   wStrb;
	reg          wHeld;
	reg          lastExt;

	wire fmtExt    = ctrl[`RCED_CTRL_FMT];
	wire cacheMode = ctrl[`RCED_CTRL_CMODE];

	// masks of pointer bits that lie below the host address width
	wire [63:0] lowMask;
	wire [63:0] highMask;
	genvar g;
	generate
		for (g = 0; g < 64; g = g + 1) begin : gMask
			assign lowMask[g]  = (g < HOST_ADDR_WIDTH) && (g >= `RCED_TABLE_SHIFT);
			assign highMask[g] = (g < HOST_ADDR_WIDTH) && (g >= `RCED_UPTR_LSB - 64);
		end
	endgenerate

	// supported tag bits; the rest of the 16-bit field is reserved
	wire [15:0] tagMask;
	generate
		for (g = 0; g < 16; g = g + 1) begin : gTag
			assign tagMask[g] = (g < TAG_WIDTH);
		end
	endgenerate

	// R14: entry taken whole
	wire [63:0] entryHi = entryData[127:64];
	wire [63:0] entryLo = entryData[63:0];
	wire [15:0] rawTag  = entryData[`RCED_DTAG_MSB:`RCED_DTAG_LSB];
	// R3: upper valid flag
	wire        uValid  = entryData[`RCED_UVALID_BIT];
	// R5: lower valid flag
	wire        lValid  = entryData[`RCED_LVALID_BIT];
	// R10: unused upper tag bits reserved
	wire        tagRsvd = |(rawTag & ~tagMask);
	// R6: context reserved bits 127:88 checked, hazard flagged not trusted; root ranges 75:65 and 11:1 not checked
	wire        ctxRsvd = |entryData[127:`RCED_CTX_RSVD_LSB];
	// R13: zero tag illegal in caching mode
	wire        tagZero = cacheMode && ((rawTag & tagMask) == 16'h0000);

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			upperTableBase <= 64'h0000000000000000;
			upperPresent   <= 1'b0;
			lowerTableBase <= 64'h0000000000000000;
			lowerPresent   <= 1'b0;
			rootDone       <= 1'b0;
			domainTag      <= 16'h0000;
			ctxDone        <= 1'b0;
			ctxRsvdErr     <= 1'b0;
			ctxTagErr      <= 1'b0;
			lastEntry      <= 128'h0;
			lastExt        <= 1'b0;
		end else begin
			rootDone <= entryValid && !entryIsContext;
			ctxDone  <= entryValid && entryIsContext;
			if (entryValid) begin
				lastEntry <= entryData;
			end
			if (entryValid && !entryIsContext) begin
				lastExt <= fmtExt;
				if (fmtExt) begin
					// R1: extended format decode
					// R2: upper pointer masked by width
					// pointer already sits at bit 12 of the upper word, so no shift
					upperTableBase <= uValid ? (entryHi & highMask) : 64'h0000000000000000;
					upperPresent   <= uValid;
				end else begin
					// R12: legacy format, no upper half
					upperTableBase <= 64'h0000000000000000;
					upperPresent   <= 1'b0;
				end
				// R4: lower pointer masked by width
				lowerTableBase <= lValid ? (entryLo & lowMask) : 64'h0000000000000000;
				lowerPresent   <= lValid;
			end
			// R7: context entry serves requests without PASID
			if (entryValid && entryIsContext) begin
				// R8: domain tag from 87:72
				domainTag  <= rawTag & tagMask;
				ctxRsvdErr <= ctxRsvd || tagRsvd;
				ctxTagErr  <= tagZero;
			end
		end
	end

	// axi write path: address and data taken in either order
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	wire   awNow    = awHeld || s_axi_awvalid;
	wire   wNow     = wHeld || s_axi_wvalid;
	wire [7:0]  wrAddr   = awHeld ? awAddr : s_axi_awaddr;
	wire [31:0] wrData   = wHeld ? wData : s_axi_wdata;
	wire [3:0]  wrStrb   = wHeld ? wStrb : s_axi_wstrb;
	wire   doWrite  = awNow && wNow && !s_axi_bvalid;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			awHeld       <= 1'b0;
			awAddr       <= 8'h00;
			wHeld        <= 1'b0;
			wData        <= 32'h00000000;
			wStrb        <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RCED_RESP_OKAY;
			ctrl         <= `RCED_CTRL_RST;
		end else begin
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (doWrite) begin
				awHeld       <= 1'b0;
				wHeld        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wrAddr == `RCED_OFF_CTRL) begin
					s_axi_bresp <= `RCED_RESP_OKAY;
					if (wrStrb[0]) begin
						ctrl <= wrData[1:0];
					end
				end else begin
					s_axi_bresp <= `RCED_RESP_SLVERR;
				end
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					awHeld <= 1'b1;
					awAddr <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					wHeld <= 1'b1;
					wData <= s_axi_wdata;
					wStrb <= s_axi_wstrb;
				end
			end
		end
	end

	// read path
	assign s_axi_arready = !s_axi_rvalid;
	localparam [4:0] TAG_W5 = TAG_WIDTH;
	reg [31:0] next_rdata;
	reg        next_rerr;
	always @* begin
		next_rdata = 32'h00000000;
		next_rerr  = 1'b0;
		case (s_axi_araddr)
			`RCED_OFF_CTRL:      next_rdata = {30'h0, ctrl};
			// R9: tag width readable
			`RCED_OFF_CAP:       next_rdata = {27'h0, TAG_W5};
			`RCED_OFF_STATUS:    next_rdata = {27'h0, ctxTagErr, ctxRsvdErr, lastExt,
				lowerPresent, upperPresent};
			`RCED_OFF_UPTR_LO:   next_rdata = upperTableBase[31:0];
			`RCED_OFF_UPTR_HI:   next_rdata = upperTableBase[63:32];
			`RCED_OFF_LPTR_LO:   next_rdata = lowerTableBase[31:0];
			`RCED_OFF_LPTR_HI:   next_rdata = lowerTableBase[63:32];
			`RCED_OFF_DTAG:      next_rdata = {16'h0, domainTag};
			8'h20:               next_rdata = lastEntry[31:0];
			8'h24:               next_rdata = lastEntry[63:32];
			8'h28:               next_rdata = lastEntry[95:64];
			8'h2C:               next_rdata = lastEntry[127:96];
			default:             next_rerr  = 1'b1;
		endcase
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RCED_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rerr ? `RCED_RESP_SLVERR : `RCED_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // rced_entry_decode

// *** verif/rced_properties.sv ***
// assertions on the decoder ports, bound from the bench
`timescale 1ns/1ps
module rced_properties #(parameter HOST_ADDR_WIDTH = 48, parameter TAG_WIDTH = 16) (
	// clock and reset
	input wire         sys_clk,
	input wire         resetn,
	// entry in and decoded results
	input wire         entryValid,
	input wire [127:0] entryData,
	input wire         entryIsContext,
	input wire [63:0]  upperTableBase,
	input wire         upperPresent,
	input wire [63:0]  lowerTableBase,
	input wire         lowerPresent,
	input wire         rootDone,
	input wire [15:0]  domainTag,
	input wire         ctxDone,
	input wire         ctxRsvdErr,
	input wire         ctxTagErr
);
	localparam [63:0] AM = (64'h1 << HOST_ADDR_WIDTH) - 64'h1;
	localparam [15:0] TM = (1 << TAG_WIDTH) - 1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	root_done_a: assert property (entryValid && !entryIsContext |=> rootDone)
		else $error("root entry not answered");
	ctx_done_a: assert property (entryValid && entryIsContext |=> ctxDone && !rootDone)
		else $error("context entry not answered");
	lower_flag_a: assert property (rootDone |-> lowerPresent == $past(entryData[0]))
		else $error("lower flag wrong");
	lower_base_a: assert property (rootDone |-> lowerTableBase ==
		(lowerPresent ? $past(entryData[63:0]) & AM & ~64'hFFF : 64'h0)) else $error("lower base");
	upper_flag_a: assert property (rootDone && upperPresent |-> $past(entryData[64]))
		else $error("upper flag wrong");
	upper_base_a: assert property (rootDone |-> upperTableBase ==
		(upperPresent ? {$past(entryData[127:76]), 12'h0} & AM : 64'h0)) else $error("upper base");
	tag_mask_a: assert property (ctxDone |-> domainTag == ($past(entryData[87:72]) & TM))
		else $error("domain tag wrong");
	tag_rsvd_a: assert property (ctxDone |-> ctxRsvdErr == (|$past(entryData[127:88]) ||
		|($past(entryData[87:72]) & ~TM))) else $error("reserved flag wrong");
	cover property (rootDone && upperPresent && lowerPresent);
	cover property (ctxDone && ctxRsvdErr);
	cover property (ctxDone && ctxTagErr);
endmodule // rced_properties

// *** verif/rced_mem_model.sv ***
// memory side model that hands fetched table entries to the decoder
`timescale 1ns/1ps
module rced_mem_model (
	// clock and fetch order
	input  wire         sys_clk,
	input  wire         fetchReq,
	input  wire [127:0] fetchData,
	input  wire         fetchCtx,
	// entry delivered to the decoder
	output reg          entryValid = 1'b0,
	output reg  [127:0] entryData = 128'h0,
	output reg          entryIsContext = 1'b0
);
	always @(posedge sys_clk) begin
		entryValid     <= fetchReq;
		entryIsContext <= fetchCtx;
		// idle lines show the inverse so stale data cannot pass
		entryData      <= fetchReq ? fetchData : ~entryData;
	end
endmodule // rced_mem_model

// *** verif/tb.sv ***
// bench for the root and context entry decoder
`timescale 1ns/1ps
`include "rced_defines.vh"
module tb;
	localparam TW = 8;
	localparam [63:0] BASE = 64'hFFFF_FFFF_F000;
	localparam [51:0] P1 = 52'hF_FFFF_FFFF_FFFF;
	reg          sys_clk = 1'b0, resetn = 1'b0, fetchReq = 1'b0, fetchCtx = 1'b0;
	reg  [127:0] fetchData = 128'h0;
	reg  [7:0]   s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	reg  [31:0]  s_axi_wdata = 32'h0;
	reg  [3:0]   s_axi_wstrb = 4'hF;
	reg          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire         entryValid, entryIsContext, upperPresent, lowerPresent, rootDone, ctxDone;
	wire         ctxRsvdErr, ctxTagErr, s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid;
	wire [127:0] entryData;
	wire [63:0]  upperTableBase, lowerTableBase;
	wire [15:0]  domainTag;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	integer      n_errors = 0, compares = 0, cyc = 0;
	always #5 sys_clk = ~sys_clk;
	rced_mem_model MEM (.*);
	rced_entry_decode #(.HOST_ADDR_WIDTH(48), .TAG_WIDTH(TW)) DUT (.*);
	task chk(input [63:0] got, input [63:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task stop_test;
		begin
			$display("errors %0d compares %0d", n_errors, compares);
			if (n_errors == 0 && compares > 0) $display("Test passed");
			else $display("Test failed");
			$finish;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		begin
			@(posedge sys_clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do @(negedge sys_clk); while (!(s_axi_awready && s_axi_wready));
			@(posedge sys_clk);
			s_axi_awvalid <= 1'b0;
			s_axi_wvalid <= 1'b0;
			do @(negedge sys_clk); while (!s_axi_bvalid);
			chk(s_axi_bresp, er);
			@(posedge sys_clk);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] d, input [1:0] er);
		begin
			@(posedge sys_clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do @(negedge sys_clk); while (!s_axi_arready);
			@(posedge sys_clk);
			s_axi_arvalid <= 1'b0;
			do @(negedge sys_clk); while (!s_axi_rvalid);
			chk(s_axi_rdata, d);
			chk(s_axi_rresp, er);
			@(posedge sys_clk);
			s_axi_rready <= 1'b0;
		end
	endtask
	// answer lands two edges after the order, then the results stand
	task fe(input [127:0] d, input c);
		begin
			@(posedge sys_clk);
			fetchReq <= 1'b1;
			fetchData <= d;
			fetchCtx <= c;
			@(posedge sys_clk);
			fetchReq <= 1'b0;
			repeat (2) @(posedge sys_clk);
			#1;
		end
	endtask
	task t_regs;
		begin
			rd(`RCED_OFF_CTRL, 32'h0, `RCED_RESP_OKAY);
			rd(`RCED_OFF_CAP, TW, `RCED_RESP_OKAY);
			rd(8'h40, 32'h0, `RCED_RESP_SLVERR);
			wr(8'h40, 32'h1, `RCED_RESP_SLVERR);
		end
	endtask
	task t_root;
		begin
			wr(`RCED_OFF_CTRL, 32'h1, `RCED_RESP_OKAY);
			fe({P1, 12'h1, P1, 12'h1}, 1'b0);
			chk(upperTableBase, BASE);
			chk(lowerTableBase, BASE);
			chk({upperPresent, lowerPresent}, 2'h3);
			rd(`RCED_OFF_STATUS, 32'h7, `RCED_RESP_OKAY);
			rd(`RCED_OFF_UPTR_LO, 32'hFFFFF000, `RCED_RESP_OKAY);
			rd(`RCED_OFF_UPTR_HI, 32'h0000FFFF, `RCED_RESP_OKAY);
			rd(`RCED_OFF_LPTR_LO, 32'hFFFFF000, `RCED_RESP_OKAY);
			rd(`RCED_OFF_LPTR_HI, 32'h0000FFFF, `RCED_RESP_OKAY);
			rd(8'h2C, 32'hFFFFFFFF, `RCED_RESP_OKAY);
			rd(`RCED_OFF_ENTRY0, 32'hFFFFF001, `RCED_RESP_OKAY);
			fe({P1, 12'hFFE, P1, 12'hFFE}, 1'b0);
			chk(upperTableBase, 64'h0);
			chk(lowerTableBase, 64'h0);
			chk({upperPresent, lowerPresent}, 2'h0);
			wr(`RCED_OFF_CTRL, 32'h0, `RCED_RESP_OKAY);
			fe({P1, 12'h1, 52'h0, 12'h1}, 1'b0);
			chk({upperPresent, lowerPresent}, 2'h1);
			chk(upperTableBase, 64'h0);
		end
	endtask
	task t_ctx;
		begin
			fe({40'h0, 16'hA55A, 72'h0}, 1'b1);
			chk(domainTag, 16'h005A);
			rd(`RCED_OFF_DTAG, 32'h0000005A, `RCED_RESP_OKAY);
			chk(ctxRsvdErr, 1'b1);
			fe({40'h1, 16'h003C, 72'h0}, 1'b1);
			chk(domainTag, 16'h003C);
			chk(ctxRsvdErr, 1'b1);
			fe({40'h0, 16'h0011, 72'hFF}, 1'b1);
			chk({ctxRsvdErr, ctxTagErr}, 2'h0);
			wr(`RCED_OFF_CTRL, 32'h2, `RCED_RESP_OKAY);
			fe(128'h0, 1'b1);
			chk(ctxTagErr, 1'b1);
		end
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors = n_errors + 1;
			stop_test;
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		t_regs;
		t_root;
		t_ctx;
		stop_test;
	end
endmodule // tb
bind rced_entry_decode rced_properties #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH),
	.TAG_WIDTH(TAG_WIDTH)) CHK (.*);
